// *** logic/safe_torque_off_monitor.sv ***
/*
 Two-channel torque cutoff monitor with APB register access and an
 interrupt. Gates the PWM signals to the power stage.
 Assumes safety inputs arrive as levels with pull-down (undriven = OFF),
 and the APB master follows the standard protocol on pclk.
*/
// Design decisions made here: the address map and the APB slave port.
// Overview of operation
// - Two independent safety channels; PWM passes only while both are ON.
// - Either channel OFF enters torque cutoff and blocks every PWM signal.
// - Monitor output asserted only when both channels are OFF.
// - Distinct cause code for only B off, only A off, both off.
// - Cutoff active from reset; undriven inputs read OFF, PWM blocked.
`timescale 1ns/1ps
`include "torque_cutoff_cfg.svh"

module safe_torque_off_monitor #(
    parameter int PWM_W = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic safety_request_a,
    input wire logic safety_request_b,
    input wire logic [PWM_W-1:0] pwm_in,
    output logic [PWM_W-1:0] pwm_out,
    output logic external_monitor_output,
    output logic [1:0] cutoff_cause,
    output logic torque_cutoff_state,
    output logic irq
);

    // ------------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------------
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    torque_cutoff_pkg::chan_state_t chan;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= `SYNC_RST;
            sync2_reg <= `SYNC_RST;
        end else begin
            sync1_reg <= {safety_request_b, safety_request_a};
            sync2_reg <= sync1_reg;
        end
    end

    assign chan = torque_cutoff_pkg::chan_state_t'(sync2_reg);

    // ------------------------------------------------------------------
    // Cause decode
    // ------------------------------------------------------------------
    function automatic logic [1:0] cause_of(
        input torque_cutoff_pkg::chan_state_t c
    );
        logic [1:0] r;
        r = `CAUSE_NONE;
        case ({c.chan_a, c.chan_b})
            2'h3: r = `CAUSE_NONE;
            2'h2: r = `CAUSE_B_OFF;
            2'h1: r = `CAUSE_A_OFF;
            default: r = `CAUSE_BOTH;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Cutoff state and outputs
    // ------------------------------------------------------------------
    torque_cutoff_pkg::mon_state_t state_reg;
    torque_cutoff_pkg::mon_state_t state_next;
    logic [PWM_W-1:0] pwm_reg;
    logic [PWM_W-1:0] pwm_next;
    logic mon_reg;
    logic mon_next;
    logic [1:0] cause_reg;
    logic [1:0] cause_next;
    logic force_reg;
    logic both_on;

    assign both_on = chan.chan_a && chan.chan_b && !force_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            torque_cutoff_pkg::ST_RUN: begin
                if (!both_on) begin
                    state_next = torque_cutoff_pkg::ST_CUTOFF;
                end
            end
            torque_cutoff_pkg::ST_CUTOFF: begin
                if (both_on) begin
                    state_next = torque_cutoff_pkg::ST_RUN;
                end
            end
            default: state_next = torque_cutoff_pkg::ST_CUTOFF;
        endcase
        pwm_next = both_on ? pwm_in : '0;
        mon_next = !chan.chan_a && !chan.chan_b;
        cause_next = cause_of(chan);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= torque_cutoff_pkg::ST_CUTOFF;
            pwm_reg <= '0;
            mon_reg <= 1'b1;
            cause_reg <= `CAUSE_BOTH;
        end else begin
            state_reg <= state_next;
            pwm_reg <= pwm_next;
            mon_reg <= mon_next;
            cause_reg <= cause_next;
        end
    end

    assign pwm_out = pwm_reg;
    assign external_monitor_output = mon_reg;
    assign cutoff_cause = cause_reg;
    assign torque_cutoff_state = state_reg;

    // ------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------
    logic [`IRQ_W-1:0] ev;
    logic [`IRQ_W-1:0] ist_reg;
    logic [`IRQ_W-1:0] ist_next;
    logic [`IRQ_W-1:0] mask_reg;
    logic [`IRQ_W-1:0] mask_next;
    logic force_next;
    logic irq_reg;
    logic irq_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ready_reg;
    logic ready_next;
    logic err_reg;
    logic err_next;
    logic wr_go;
    logic rd_go;
    logic map_hit;

    always_comb begin
        ev = '0;
        ev[`IRQ_ENTER] = (state_reg == torque_cutoff_pkg::ST_RUN) &&
                         (state_next == torque_cutoff_pkg::ST_CUTOFF);
        ev[`IRQ_LEAVE] = (state_reg == torque_cutoff_pkg::ST_CUTOFF) &&
                         (state_next == torque_cutoff_pkg::ST_RUN);
        ev[`IRQ_CAUSE] = (cause_next != cause_reg);
    end

    // ------------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------------
    assign map_hit = (paddr == `OFS_STATUS) || (paddr == `OFS_IRQ_STATUS) ||
                     (paddr == `OFS_IRQ_MASK) || (paddr == `OFS_CONTROL);
    assign wr_go = psel && penable && ready_reg && pwrite && map_hit;
    assign rd_go = psel && penable && !ready_reg && !pwrite;

    always_comb begin
        ist_next = ist_reg;
        mask_next = mask_reg;
        force_next = force_reg;
        if (wr_go && paddr == `OFS_IRQ_STATUS) begin
            ist_next = ist_reg & ~pwdata[`IRQ_W-1:0];
        end
        if (wr_go && paddr == `OFS_IRQ_MASK) begin
            mask_next = pwdata[`IRQ_W-1:0];
        end
        if (wr_go && paddr == `OFS_CONTROL) begin
            force_next = pwdata[`CTRL_FORCE_BIT];
        end
        ist_next = ist_next | ev;
        irq_next = |(ist_next & mask_next);
        ready_next = psel && penable && !ready_reg;
        err_next = ready_next && !map_hit;
        rdata_next = rdata_reg;
        if (rd_go) begin
            case (paddr)
                `OFS_STATUS: rdata_next = {26'h0, cause_reg,
                    mon_reg, torque_cutoff_state, chan.chan_b, chan.chan_a};
                `OFS_IRQ_STATUS: rdata_next = {29'h0, ist_reg};
                `OFS_IRQ_MASK: rdata_next = {29'h0, mask_reg};
                `OFS_CONTROL: rdata_next = {31'h0, force_reg};
                default: rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_reg <= '0;
            mask_reg <= `MASK_RST;
            force_reg <= 1'b0;
            irq_reg <= 1'b0;
            rdata_reg <= 32'h0;
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            ist_reg <= ist_next;
            mask_reg <= mask_next;
            force_reg <= force_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            err_reg <= err_next;
        end
    end

    assign prdata = rdata_reg;
    assign pready = ready_reg;
    assign pslverr = err_reg;
    assign irq = irq_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence both_on_s;
        sync2_reg == 2'h3 && !force_reg;
    endsequence

    pwm_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        both_on_s |=> pwm_out == $past(pwm_in))
        else $error("PWM not passed with both channels on");
    pwm_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sync2_reg != 2'h3) |=> pwm_out == '0 && torque_cutoff_state)
        else $error("PWM not blocked with a channel off");
    mon_both_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 external_monitor_output == ($past(sync2_reg) == 2'h0))
        else $error("Monitor output wrong for channel pair");
    cause_b_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sync2_reg == 2'h1) |=> cutoff_cause == `CAUSE_B_OFF)
        else $error("Cause wrong for only B off");
    cause_a_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sync2_reg == 2'h2) |=> cutoff_cause == `CAUSE_A_OFF)
        else $error("Cause wrong for only A off");
    sync_lag_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) && $past(presetn, 2) |->
            sync2_reg == $past({safety_request_b, safety_request_a}, 2))
        else $error("Synchroniser latency not two cycles");
    reset_off_a: assert property (@(posedge pclk)
        $rose(presetn) |-> pwm_out == '0 && external_monitor_output)
        else $error("Cutoff not active out of reset");
    irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(ist_reg & mask_reg))
        else $error("Interrupt level not masked status");

    // ------------------------------------------------------------------
    // Cutoff, register bus and interrupt assertions
    // ------------------------------------------------------------------
    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence apb_access_s;
        apb_setup_s ##1 (psel && penable);
    endsequence

    cause_both_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (sync2_reg == 2'h0) |=> cutoff_cause == `CAUSE_BOTH)
        else $error("Cause wrong for both off");
    mon_cut_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        external_monitor_output |-> torque_cutoff_state)
        else $error("Monitor output without cutoff");
    run_again_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        torque_cutoff_state ##0 both_on_s |=> !torque_cutoff_state)
        else $error("Cutoff held with both channels on");
    force_cut_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        force_reg |=> torque_cutoff_state && pwm_out == '0)
        else $error("Software cutoff not applied");

    apb_wait_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        apb_access_s |=> pready)
        else $error("Access not answered after one wait state");
    ready_pulse_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        pready |=> !pready)
        else $error("Ready held longer than one cycle");
    apb_err_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        pready |-> pslverr == !(paddr inside {`OFS_STATUS,
            `OFS_IRQ_STATUS, `OFS_IRQ_MASK, `OFS_CONTROL}))
        else $error("Error response wrong for address");
    err_data_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("Refused read returned data");

    ev_set_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (ev != '0) |=> (ist_reg & $past(ev)) == $past(ev))
        else $error("Event lost against a clear");
    ist_hold_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        !(wr_go && paddr == `OFS_IRQ_STATUS) |=>
            (ist_reg & $past(ist_reg)) == $past(ist_reg))
        else $error("Status bit cleared without a write");

endmodule // safe_torque_off_monitor

// *** logic/torque_cutoff_cfg.svh ***
/*
 Constants for the torque cutoff monitor: register offsets, field
 positions, reset values and cutoff cause codes.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef TORQUE_CUTOFF_CFG_SVH
`define TORQUE_CUTOFF_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_STATUS 12'h000
`define OFS_IRQ_STATUS 12'h004
`define OFS_IRQ_MASK 12'h008
`define OFS_CONTROL 12'h00c

// ----------------------------------------------------------------------
// Cause codes: none, both off, only a off, only b off
// ----------------------------------------------------------------------
`define CAUSE_NONE 2'h0
`define CAUSE_BOTH 2'h1
`define CAUSE_A_OFF 2'h2
`define CAUSE_B_OFF 2'h3

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define IRQ_W 3
`define IRQ_ENTER 0
`define IRQ_LEAVE 1
`define IRQ_CAUSE 2
`define MASK_RST 3'h0
`define CTRL_FORCE_BIT 0
`define SYNC_RST 2'h0

`endif

// *** logic/torque_cutoff_pkg.sv ***
/*
 Types for the torque cutoff monitor.
 Assumes the cfg header is on the include path.
*/
`include "torque_cutoff_cfg.svh"

package torque_cutoff_pkg;

    // Synchronised channel levels, high means ON
    typedef struct packed {
        logic chan_b;
        logic chan_a;
    } chan_state_t;

    // Monitor state
    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_CUTOFF = 1'b1
    } mon_state_t;

endpackage

// *** test/safety_switch_model.sv ***
/*
 Model of the external safety switch driving both request channels.
 Assumes the bench sets the wanted levels and the plug state.
*/
`timescale 1ns/1ps

module safety_switch_model (
    input wire logic pclk,
    input wire logic plugged,
    input wire logic [1:0] want_on,
    output logic safety_request_a,
    output logic safety_request_b
);
    logic [1:0] level_reg;

    // Contacts change just after an edge
    always_ff @(posedge pclk) begin
        level_reg <= want_on;
    end

    // Unplugged lines fall to the pull-down level, read as OFF
    assign safety_request_a = plugged & level_reg[0];
    assign safety_request_b = plugged & level_reg[1];
endmodule // safety_switch_model

// *** test/test_safe_torque_off_monitor.sv ***
/*
 Self-checking bench for the torque cutoff monitor.
 Assumes the cfg header on the include path and the switch model.
*/
`timescale 1ns/1ps
`include "torque_cutoff_cfg.svh"

module test_safe_torque_off_monitor;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] pwm_in, pwm_out;
    logic safety_request_a, safety_request_b, plugged, irq;
    logic external_monitor_output, torque_cutoff_state;
    logic [1:0] cutoff_cause, want_on, on_prev;
    logic [3:0] e;
    int failures, num_checks, seed, k;

    safe_torque_off_monitor #(.PWM_W(6)) DUT (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .safety_request_a(safety_request_a),
        .safety_request_b(safety_request_b), .pwm_in(pwm_in),
        .pwm_out(pwm_out),
        .external_monitor_output(external_monitor_output),
        .cutoff_cause(cutoff_cause),
        .torque_cutoff_state(torque_cutoff_state), .irq(irq));

    safety_switch_model partner (.pclk(pclk), .plugged(plugged),
        .want_on(want_on), .safety_request_a(safety_request_a),
        .safety_request_b(safety_request_b));

    // ------------------------------------------------------------------
    // Expectations and checking
    // ------------------------------------------------------------------
    // {cutoff, monitor, cause}; on[0] is channel a
    function automatic logic [3:0] expect_out(input logic [1:0] on);
        case (on)
            2'h3: return {2'b00, `CAUSE_NONE};
            2'h2: return {2'b10, `CAUSE_A_OFF};
            2'h1: return {2'b10, `CAUSE_B_OFF};
            default: return {2'b11, `CAUSE_BOTH};
        endcase
    endfunction

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %0t: %s got %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic check_outs(input logic [1:0] on, input string what);
        check({28'h0, torque_cutoff_state, external_monitor_output,
               cutoff_cause}, {28'h0, expect_out(on)}, what);
    endtask

    // One APB transfer, released after pready is seen
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            check(32'h0, 32'h1, "apb timeout");
            close_out();
        end else begin
            @(posedge pclk);
        end
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 86;
        failures = 0;
        num_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pwm_in = 6'h3f;
        plugged = 1'b0;
        want_on = 2'h0;
        repeat (16) @(posedge pclk);
        check_outs(2'h0, "in reset");
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        check_outs(2'h0, "unplugged");
        check({26'h0, pwm_out}, 32'h0, "pwm unplugged");
        $display("Reset test done");
        plugged <= 1'b1;
        on_prev = 2'h0;
        for (k = 0; k < 12; k++) begin
            want_on <= (k < 4) ? k[1:0] : 2'($random(seed));
            pwm_in <= 6'($random(seed));
            repeat (3) @(posedge pclk);
            check_outs(on_prev, "before sync");
            repeat (3) @(posedge pclk);
            on_prev = want_on;
            check_outs(on_prev, "after sync");
            check({26'h0, pwm_out}, {26'h0, (&on_prev) ? pwm_in : 6'h0},
                  "pwm gate");
            e = expect_out(on_prev);
            apb(1'b0, `OFS_STATUS, 32'h0);
            check(rd, {26'h0, e[1:0], e[2], e[3], on_prev}, "status");
            check({31'h0, err}, 32'h0, "status err");
            $display("Step %0d done", k);
        end
        want_on <= 2'h3;
        repeat (8) @(posedge pclk);
        apb(1'b1, `OFS_IRQ_STATUS, 32'h7);
        apb(1'b1, `OFS_IRQ_MASK, 32'h1);
        apb(1'b0, `OFS_IRQ_MASK, 32'h0);
        check(rd, 32'h1, "mask readback");
        check({31'h0, irq}, 32'h0, "irq idle");
        want_on <= 2'h2;
        repeat (8) @(posedge pclk);
        check({31'h0, irq}, 32'h1, "irq on cutoff");
        apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
        check(rd, (32'h1 << `IRQ_ENTER) | (32'h1 << `IRQ_CAUSE),
              "enter and cause events");
        apb(1'b1, `OFS_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0, "irq cleared");
        apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
        check(rd, 32'h1 << `IRQ_CAUSE, "only enter cleared");
        want_on <= 2'h3;
        repeat (8) @(posedge pclk);
        apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
        check(rd, (32'h1 << `IRQ_LEAVE) | (32'h1 << `IRQ_CAUSE),
              "leave event");
        apb(1'b1, `OFS_CONTROL, 32'h1);
        repeat (2) @(posedge pclk);
        check({28'h0, torque_cutoff_state, external_monitor_output,
               cutoff_cause}, {28'h0, 2'b10, `CAUSE_NONE}, "forced cut");
        check({26'h0, pwm_out}, 32'h0, "pwm forced off");
        apb(1'b0, `OFS_CONTROL, 32'h0);
        check(rd, 32'h1, "control readback");
        apb(1'b1, `OFS_CONTROL, 32'h0);
        repeat (2) @(posedge pclk);
        check_outs(2'h3, "force released");
        check({26'h0, pwm_out}, {26'h0, pwm_in}, "pwm after force");
        apb(1'b0, 12'h010, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped err");
        check(rd, 32'h0, "unmapped data");
        apb(1'b1, 12'h010, 32'h7);
        check({31'h0, err}, 32'h1, "unmapped write err");
        $display("Register test done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        check_outs(2'h0, "mid reset");
        presetn <= 1'b1;
        @(posedge pclk);
        check_outs(2'h0, "first edge after release");
        check({26'h0, pwm_out}, 32'h0, "pwm after release");
        repeat (4) @(posedge pclk);
        check_outs(2'h3, "run after release");
        apb(1'b0, `OFS_IRQ_MASK, 32'h0);
        check(rd, {29'h0, `MASK_RST}, "mask after reset");
        $display("Reset again test done");
        close_out();
    end
endmodule // test_safe_torque_off_monitor
